// File: hw/nibble_defs.svh
// constants for the nibble serial / loopback / receiver power-save block
// assumes a 16-bit plain register port and one clock at the pll rate
// Notes on behaviour
// - serial receive mode leaves the transmit path exactly as without it.
// - serial mode derives the capture clock from the pll clock, not a strobe.
// - each slice may feed its tx data back into rx while still driving pad.
// - loopback needs data and strobe slices; only slice zero takes strobe.
// - at power-on receiver-off and termination-off outputs are both high.
// - state machine output falls two divided cycles after read enable rises.
// - after read enable falls output stays low idle-count plus one divided cycles, then high.
// - source attribute and termination bit pick machine, zero or fabric.
// - fabric-controlled outputs carry the or of all read enables on every bit.
`ifndef NIBBLE_DEFS_SVH
`define NIBBLE_DEFS_SVH

`define OFS_MODE      8'h00
`define OFS_LOOPBACK  8'h01
`define OFS_SOURCES   8'h02
`define OFS_TERM_BITS 8'h03
`define OFS_IDLE_CNT  8'h04
`define OFS_STATUS    8'h05

`define MODE_SERIAL_BIT 0
`define MODE_WIDTH_LSB  4
`define MODE_WIDTH_MSB  7
`define SRC_RCV_LSB     8

`define RST_WIDTH    4'h8
`define RST_IDLE_CNT 8'h0F
`define RST_MODE     16'h0080

`endif

// File: hw/nibble_pkg.sv
// types shared by the nibble power-save logic
// assumes nothing beyond the defs header
package nibble_pkg;
  // gray order along high -> arm -> low -> hold
  typedef enum logic [1:0] {
    PS_HIGH = 2'b00,
    PS_ARM  = 2'b01,
    PS_LOW  = 2'b11,
    PS_HOLD = 2'b10
  } ps_state_t;
endpackage : nibble_pkg

// File: hw/nibble_serial_loopback_rx_power.sv
// nibble control: serial capture clocking, per-slice loopback, receiver power save
// assumes clk is the pll clock, read enables come from fabric on clk, pad inputs async
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "nibble_defs.svh"
module nibble_serial_loopback_rx_power #(
  parameter int NSLICE = 6,
  parameter int CNT_W  = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [15:0]       reg_rdata,
  // slice datapath
  input  wire logic [NSLICE-1:0] tx_data,
  input  wire logic [NSLICE-1:0] pad_data_in,
  output logic      [NSLICE-1:0] serial_data_out,
  output logic      [NSLICE-1:0] rx_data,
  output logic                   capture_pulse,
  // power save
  input  wire logic [NSLICE-1:0] read_window_enable,
  output logic      [NSLICE-1:0] receiver_off,
  output logic      [NSLICE-1:0] termination_off
);
  logic [15:0]       mode_r;
  logic [NSLICE-1:0] loop_r;
  logic [NSLICE-1:0] term_src_r;
  logic [NSLICE-1:0] rcv_src_r;
  logic [NSLICE-1:0] term_bit_r;
  logic [CNT_W-1:0]  idle_r;
  logic [15:0]       rdata_r;
  logic [NSLICE-1:0] pad_s1_r;
  logic [NSLICE-1:0] pad_s2_r;
  logic [NSLICE-1:0] ser_out_r;
  logic [NSLICE-1:0] rx_r;
  logic              strobe_prev_r;
  logic              cap_r;
  logic [3:0]        div_r;
  logic [NSLICE-1:0] rcv_off_r;
  logic [NSLICE-1:0] term_off_r;

  // register decode
  wire wr_mode = reg_wr && reg_addr == `OFS_MODE;
  wire wr_loop = reg_wr && reg_addr == `OFS_LOOPBACK;
  wire wr_src  = reg_wr && reg_addr == `OFS_SOURCES;
  wire wr_term = reg_wr && reg_addr == `OFS_TERM_BITS;
  wire wr_idle = reg_wr && reg_addr == `OFS_IDLE_CNT;

  wire             serial_on = mode_r[`MODE_SERIAL_BIT];
  wire [3:0]       width     = mode_r[`MODE_WIDTH_MSB:`MODE_WIDTH_LSB];
  wire [3:0]       width_m1  = (width == 4'h0) ? 4'h0 : width - 4'h1;
  wire             div_tick  = (div_r >= width_m1);
  wire             rden_any  = |read_window_enable;
  wire             sm_out;
  nibble_pkg::ps_state_t ps_state;

  // per-slice receive source: own tx ahead of the pad, else synced pad data
  wire [NSLICE-1:0] rx_sel = (loop_r & tx_data) | (~loop_r & pad_s2_r);
  // only slice zero can carry a strobe into the capture logic
  wire strobe_edge = rx_sel[0] & ~strobe_prev_r;
  wire cap_nxt     = serial_on ? div_tick : strobe_edge;

  // output source selection, one entry per slice
  // a set termination bit forces an internally sourced output to zero by itself,
  // whatever source the other output of the same slice uses
  logic [NSLICE-1:0] rcv_off_nxt;
  logic [NSLICE-1:0] term_off_nxt;
  genvar k;
  generate
    for (k = 0; k < NSLICE; k++) begin : g_src
      assign term_off_nxt[k] = term_src_r[k] ? rden_any :
                               (term_bit_r[k] ? 1'b0 : sm_out);
      assign rcv_off_nxt[k]  = rcv_src_r[k] ? rden_any :
                               (term_bit_r[k] ? 1'b0 : sm_out);
    end
  endgenerate

  wire [15:0] status = {12'h000, serial_on, sm_out, ps_state};
  wire [15:0] rd_mux =
    (reg_addr == `OFS_MODE)      ? mode_r :
    (reg_addr == `OFS_LOOPBACK)  ? 16'(loop_r) :
    (reg_addr == `OFS_SOURCES)   ? (16'(rcv_src_r) << `SRC_RCV_LSB) | 16'(term_src_r) :
    (reg_addr == `OFS_TERM_BITS) ? 16'(term_bit_r) :
    (reg_addr == `OFS_IDLE_CNT)  ? 16'(idle_r) :
    (reg_addr == `OFS_STATUS)    ? status : 16'h0000;

  // register file; read data stand one cycle, zero otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      mode_r     <= `RST_MODE;
      loop_r     <= '0;
      term_src_r <= '0;
      rcv_src_r  <= '0;
      term_bit_r <= '0;
      idle_r     <= CNT_W'(`RST_IDLE_CNT);
      rdata_r    <= 16'h0000;
    end else begin
      if (wr_mode) mode_r <= reg_wdata;
      if (wr_loop) loop_r <= reg_wdata[NSLICE-1:0];
      if (wr_src) begin
        term_src_r <= reg_wdata[NSLICE-1:0];
        rcv_src_r  <= reg_wdata[`SRC_RCV_LSB +: NSLICE];
      end
      if (wr_term) term_bit_r <= reg_wdata[NSLICE-1:0];
      if (wr_idle) idle_r <= reg_wdata[CNT_W-1:0];
      rdata_r <= reg_rd ? rd_mux : 16'h0000;
    end
  end

  // pad inputs cross in through two flops
  always_ff @(posedge clk) begin
    if (srst) begin
      pad_s1_r <= '0;
      pad_s2_r <= '0;
    end else begin
      pad_s1_r <= pad_data_in;
      pad_s2_r <= pad_s1_r;
    end
  end

  // slice datapath: tx copy, rx source, capture pulse and rate divider
  always_ff @(posedge clk) begin
    if (srst) begin
      ser_out_r     <= '0;
      rx_r          <= '0;
      strobe_prev_r <= 1'b0;
      cap_r         <= 1'b0;
      div_r         <= 4'h0;
    end else begin
      ser_out_r     <= tx_data;
      rx_r          <= rx_sel;
      strobe_prev_r <= rx_sel[0];
      cap_r         <= cap_nxt;
      div_r         <= div_tick ? 4'h0 : div_r + 4'h1;
    end
  end

  // power-on state: receiver off and termination inactive
  always_ff @(posedge clk) begin
    if (srst) begin
      rcv_off_r  <= '1;
      term_off_r <= '1;
    end else begin
      rcv_off_r  <= rcv_off_nxt;
      term_off_r <= term_off_nxt;
    end
  end

  power_save_fsm #(
    .CNT_W (CNT_W)
  ) u_fsm (
    .clk        (clk),
    .srst       (srst),
    .tick       (div_tick),
    .rden_any   (rden_any),
    .idle_count (idle_r),
    .sm_out     (sm_out),
    .state      (ps_state)
  );

  assign reg_rdata       = rdata_r;
  assign serial_data_out = ser_out_r;
  assign rx_data         = rx_r;
  assign capture_pulse   = cap_r;
  assign receiver_off    = rcv_off_r;
  assign termination_off = term_off_r;

  a_tx_unaffected: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) |-> serial_data_out == $past(tx_data))
    else $error("transmit output must follow tx data in every mode");
  a_loop_route: assert property (@(posedge clk) disable iff (srst)
    (loop_r[0] && !wr_loop) |=> (rx_data[0] == $past(tx_data[0]) && serial_data_out[0] == $past(tx_data[0])))
    else $error("looped slice must receive its own tx data and still drive it out");
  a_serial_capture: assert property (@(posedge clk) disable iff (srst)
    (serial_on && div_tick) |=> capture_pulse)
    else $error("serial mode must capture on the divided pll tick");
  a_strobe_slice0: assert property (@(posedge clk) disable iff (srst)
    (!serial_on && rx_sel[0] && !strobe_prev_r) |=> capture_pulse)
    else $error("slice zero strobe edge must raise capture");
  a_power_on_high: assert property (@(posedge clk)
    $past(srst) |-> (&receiver_off && &termination_off))
    else $error("reset must leave both power-save outputs high");
  a_ext_broadcast: assert property (@(posedge clk) disable iff (srst)
    term_src_r[0] && !wr_src |=> termination_off == {NSLICE{$past(rden_any)}} || !(&$past(term_src_r)))
    else $error("fabric-controlled output must carry the or of read enables");
  a_int_forced_low: assert property (@(posedge clk) disable iff (srst)
    (!term_src_r[0] && term_bit_r[0] && !rcv_src_r[0]) |=> (!termination_off[0] && !receiver_off[0]))
    else $error("internal source with termination bit set must drive zero");
  a_int_follows_sm: assert property (@(posedge clk) disable iff (srst)
    (!term_src_r[0] && !term_bit_r[0]) |=> termination_off[0] == $past(sm_out))
    else $error("internal source with bit clear must follow the state machine");
  a_rcv_forced_low: assert property (@(posedge clk) disable iff (srst)
    (!rcv_src_r[0] && term_bit_r[0]) |=> !receiver_off[0])
    else $error("internal receiver source with termination bit set must drive zero");
  a_rcv_broadcast: assert property (@(posedge clk) disable iff (srst)
    (&rcv_src_r && !wr_src) |=> receiver_off == {NSLICE{$past(rden_any)}})
    else $error("fabric-controlled receiver output must carry the or of read enables");
  a_step_on_tick: assert property (@(posedge clk) disable iff (srst)
    !div_tick |=> ps_state == $past(ps_state))
    else $error("power-save state may only move on a divided tick");
  a_tick_spacing: assert property (@(posedge clk) disable iff (srst)
    (div_tick && width_m1 != 4'h0 && !wr_mode) |=> !div_tick)
    else $error("divided tick must not repeat on consecutive cycles above width one");
endmodule : nibble_serial_loopback_rx_power

// File: hw/power_save_fsm.sv
// receiver power-save state machine, stepped on the divided tick
// assumes tick is a one-cycle pulse from the parent's divider
`timescale 1ns/10ps
module power_save_fsm #(
  parameter int CNT_W = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // control
  input  wire logic             tick,
  input  wire logic             rden_any,
  input  wire logic [CNT_W-1:0] idle_count,
  // state
  output logic                  sm_out,
  output nibble_pkg::ps_state_t state
);
  nibble_pkg::ps_state_t st_r;
  nibble_pkg::ps_state_t st_nxt;
  logic [CNT_W-1:0]      cnt_r;
  logic [CNT_W-1:0]      cnt_nxt;

  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    if (tick) begin
      unique case (st_r)
        nibble_pkg::PS_HIGH: if (rden_any) st_nxt = nibble_pkg::PS_ARM;
        nibble_pkg::PS_ARM:  st_nxt = nibble_pkg::PS_LOW;
        nibble_pkg::PS_LOW: begin
          if (!rden_any) begin
            if (idle_count == '0) begin
              st_nxt = nibble_pkg::PS_HIGH;
            end else begin
              st_nxt  = nibble_pkg::PS_HOLD;
              cnt_nxt = idle_count - 1'b1;
            end
          end
        end
        nibble_pkg::PS_HOLD: begin
          if (rden_any) begin
            st_nxt = nibble_pkg::PS_LOW;
          end else if (cnt_r == '0) begin
            st_nxt = nibble_pkg::PS_HIGH;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r  <= nibble_pkg::PS_HIGH;
      cnt_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign sm_out = (st_r == nibble_pkg::PS_HIGH) || (st_r == nibble_pkg::PS_ARM);
  assign state  = st_r;

  a_arm_first_tick: assert property (@(posedge clk) disable iff (srst)
    (st_r == nibble_pkg::PS_HIGH && tick && rden_any) |=> (sm_out && st_r == nibble_pkg::PS_ARM))
    else $error("first divided tick after read enable must keep output high");
  a_fall_second_tick: assert property (@(posedge clk) disable iff (srst)
    (st_r == nibble_pkg::PS_ARM && tick) |=> !sm_out)
    else $error("output must fall on the second divided tick");
  a_hold_stays_low: assert property (@(posedge clk) disable iff (srst)
    (st_r == nibble_pkg::PS_LOW && tick && !rden_any && idle_count > 1)
      |=> (!sm_out && cnt_r == $past(idle_count) - 1))
    else $error("idle hold must load the idle count and stay low");
  a_hold_release: assert property (@(posedge clk) disable iff (srst)
    (st_r == nibble_pkg::PS_HOLD && tick && !rden_any && cnt_r == '0) |=> sm_out)
    else $error("output must return high when the idle count expires");
endmodule : power_save_fsm

// File: verif/fabric_model.sv
// fabric-side model: read enables and the far end of each pad input
// assumes the bench requests read enables on clk; pads float when undriven
`timescale 1ns/10ps
module fabric_model (
  // clock
  input  wire logic       clk,
  // requests from the bench
  input  wire logic [5:0] rden_req,
  // toward the nibble
  output logic      [5:0] read_window_enable,
  output logic      [5:0] pad_data_in
);
  logic [5:0] pad_r = 6'h2a;
  assign read_window_enable = rden_req;
  // no buffer drives the pad here, so the line wanders every cycle
  always @(posedge clk) pad_r <= ~pad_r;
  assign pad_data_in = pad_r;
endmodule : fabric_model

// File: verif/tb_top.sv
// self-checking bench for the nibble serial, loopback and receiver power-save block
// assumes the register map of nibble_defs.svh and the fabric model on the read enables
`timescale 1ns/10ps
`include "nibble_defs.svh"
module tb_top;
  logic        clk;
  logic        srst;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [5:0]  tx_data;
  logic [5:0]  pad_data_in;
  logic [5:0]  serial_data_out;
  logic [5:0]  rx_data;
  logic        capture_pulse;
  logic [5:0]  rden_req;
  logic [5:0]  read_window_enable;
  logic [5:0]  receiver_off;
  logic [5:0]  termination_off;
  logic [15:0] v;
  int          bad_count;
  int          samples_checked;
  int          n;

  initial clk = 1'b0;
  always #5 clk = ~clk;

  nibble_serial_loopback_rx_power #(.NSLICE(6), .CNT_W(8)) u_nibble_serial_loopback_rx_power (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_data(tx_data), .pad_data_in(pad_data_in),
    .serial_data_out(serial_data_out), .rx_data(rx_data), .capture_pulse(capture_pulse),
    .read_window_enable(read_window_enable), .receiver_off(receiver_off),
    .termination_off(termination_off));

  fabric_model u_fabric_model (.clk(clk), .rden_req(rden_req),
    .read_window_enable(read_window_enable), .pad_data_in(pad_data_in));

  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic check_out(input logic [15:0] exp);
    repeat (3) @(posedge clk);
    #1 check({4'h0, receiver_off, termination_off}, exp);
  endtask : check_out

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  // edges until receiver_off reaches exp, counted from the launching edge
  task automatic edges_until(input logic [5:0] exp, output int cnt);
    cnt = 0;
    while (receiver_off !== exp) begin
      @(posedge clk);
      #1 cnt++;
      if (cnt > 50) begin
        bad_count++;
        complete_run();
      end
    end
  endtask : edges_until

  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_data = 6'h00;
    rden_req = 6'h00;
    bad_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    #1 check({4'h0, receiver_off, termination_off}, 16'h0fff);
    reg_read(`OFS_MODE, v);
    check(v, `RST_MODE);
    reg_read(`OFS_IDLE_CNT, v);
    check(v, {8'h00, `RST_IDLE_CNT});
    reg_write(8'h3c, 16'hffff);
    reg_read(8'h3c, v);
    check(v, 16'h0000);
    // serial mode, width 4: tx untouched, capture tick every 4 cycles
    reg_write(`OFS_MODE, 16'h0041);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tx_data <= 6'(i * 9);
      #1 if (i > 0) check({10'h000, serial_data_out}, {10'h000, 6'((i - 1) * 9)});
    end
    n = 0;
    repeat (16) begin
      @(posedge clk);
      #1 n += int'(capture_pulse);
    end
    check(16'(n), 16'h0004);
    // serial off, width 1, every slice looped back
    reg_write(`OFS_MODE, 16'h0010);
    reg_write(`OFS_LOOPBACK, 16'h003f);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      tx_data <= 6'(i * 13 + 5);
      #1 if (i > 0) check({2'h0, rx_data, 2'h0, serial_data_out},
                          {2'h0, 6'((i - 1) * 13 + 5), 2'h0, 6'((i - 1) * 13 + 5)});
    end
    reg_read(`OFS_LOOPBACK, v);
    check(v, 16'h003f);
    reg_write(`OFS_LOOPBACK, 16'h0000);
    // the pad toggles every cycle, so its copy three flops late reads inverted
    repeat (3) @(posedge clk);
    #1 check({10'h000, rx_data}, {10'h000, ~pad_data_in});
    // state machine paced on every cycle
    reg_write(`OFS_IDLE_CNT, 16'h0003);
    reg_read(`OFS_STATUS, v);
    check(v, 16'h0004);
    @(posedge clk);
    rden_req <= 6'h04;
    #1 edges_until(6'h00, n);
    check(16'(n), 16'h0003);
    check({10'h000, termination_off}, 16'h0000);
    @(posedge clk);
    rden_req <= 6'h00;
    #1 edges_until(6'h3f, n);
    check(16'(n), 16'h0005);
    // source selection table
    reg_write(`OFS_TERM_BITS, 16'h003f);
    check_out(16'h0000);
    reg_write(`OFS_TERM_BITS, 16'h0000);
    reg_write(`OFS_SOURCES, 16'h003f);
    check_out(16'h0fc0);
    reg_write(`OFS_SOURCES, 16'h3f3f);
    rden_req <= 6'h01;
    check_out(16'h0fff);
    @(posedge clk);
    rden_req <= 6'h00;
    check_out(16'h0000);
    // termination external, receiver internal, bit set: receiver forced on
    reg_write(`OFS_TERM_BITS, 16'h003f);
    reg_write(`OFS_SOURCES, 16'h003f);
    rden_req <= 6'h01;
    check_out(16'h003f);
    reg_write(`OFS_SOURCES, 16'h3f00);
    check_out(16'h0fc0);
    complete_run();
  end
endmodule : tb_top
